/* File: logic/fav_pkg.sv */
// package of constants, enumerations and state types for the autovector and wakeup block
package fav_pkg;

	// ****************************************
	// clock and timing
	// ****************************************
	localparam int unsigned CLK_HZ = 40_000_000;
	localparam int unsigned CLK_PERIOD_NS = 25;
	localparam int unsigned PLL_STABLE_NS = 1000;
	localparam int unsigned PLL_STABLE_CYC = (PLL_STABLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [7:0] PLL_CNT_LOAD = 8'(PLL_STABLE_CYC);
	localparam int unsigned RESET_HOLD_US = 200;

	// ****************************************
	// register byte offsets
	// ****************************************
	localparam logic [11:0] OFS_SETUP = 12'h000;
	localparam logic [11:0] OFS_SRC_EN = 12'h004;
	localparam logic [11:0] OFS_SRC_PEND = 12'h008;
	localparam logic [11:0] OFS_VECTOR = 12'h00C;
	localparam logic [11:0] OFS_PWR = 12'h010;
	localparam logic [11:0] OFS_IRQ_STAT = 12'h014;
	localparam logic [11:0] OFS_IRQ_CLR = 12'h018;
	localparam logic [11:0] OFS_IRQ_EN = 12'h01C;
	localparam logic [11:0] OFS_GPIO = 12'h020;
	localparam logic [11:0] OFS_WAVE_BASE = 12'h400;
	localparam logic [11:0] OFS_WAVE_LAST = 12'h47C;

	// ****************************************
	// field positions
	// ****************************************
	localparam int unsigned SETUP_AV_EN = 0;
	localparam int unsigned SETUP_WU2_EN = 1;
	localparam int unsigned SETUP_WAKE_POL = 2;
	localparam int unsigned SETUP_WU2_POL = 3;
	localparam int unsigned SETUP_WU2_GPIO = 4;
	localparam int unsigned PWR_DOWN_BIT = 0;
	localparam int unsigned STAT_WAKE = 0;
	localparam int unsigned STAT_BLOCKED = 1;
	localparam int unsigned GPIO_OUT = 0;
	localparam int unsigned GPIO_OE = 1;
	localparam int unsigned GPIO_IN = 2;

	// ****************************************
	// vectoring
	// ****************************************
	localparam int unsigned NUM_SRC = 14;
	localparam logic [7:0] VEC_BASE = 8'h80;
	localparam logic [15:0] VEC_PAGE_LOC = 16'h0054;
	localparam logic [15:0] VEC_BYTE_LOC = 16'h0055;
	localparam logic [15:0] JUMP_LOC = 16'h0053;
	localparam int unsigned WAVE_WORDS = 32;

	// ****************************************
	// types
	// ****************************************
	typedef enum logic [1:0] {PW_RUN, PW_DOWN, PW_LOCK} fav_pwr_t;

	typedef struct packed {
		logic usb_activity;
		logic wake_pin;
		logic wu2_pin;
	} fav_pins_t;

	typedef struct packed {
		fav_pins_t sync1;
		fav_pins_t sync2;
		logic wu2_prev;
		logic rd_pend;
		logic wr_pend;
		logic [11:0] acc_addr;
		logic hreadyout;
		logic [31:0] hrdata;
		logic [4:0] setup;
		logic [NUM_SRC-1:0] src_en;
		logic [NUM_SRC-1:0] src_prev;
		logic [NUM_SRC-1:0] pend;
		logic [1:0] stat;
		logic [1:0] irq_en;
		logic [1:0] gpio;
		fav_pwr_t pstate;
		logic [7:0] pll_cnt;
		logic osc_en;
		logic pll_en;
		logic irq;
		logic suspended;
		logic wu2_oe;
		logic group_irq;
		logic [7:0] code_rdata;
		logic take_stage;
		logic push_pc;
		logic redirect;
		logic [15:0] redirect_addr;
		logic [WAVE_WORDS-1:0][31:0] wave;
	} fav_state_t;

endpackage

/* File: logic/fav_top.sv */
// interrupt autovectoring, power-down and wakeup logic with an AHB-Lite register port
//
// Added by the designer: register access over AHB-Lite and the register addresses.
`timescale 1ns/1ps

// Function
// R1 - endpoint level-flag sources rank 1..4, vectors 80,84,88,8C
// R2 - endpoint empty-flag sources rank 5..8, vectors 90..9C
// R3 - full flags rank 9..12 (A0..AC), op-complete 13 (B0), waveform 14 (B4)
// R4 - lowest priority number among enabled pending sources supplies the vector
// R5 - autovector enabled: byte at 0x0055 replaced by the active vector
// R6 - on interrupt take, push program counter then fetch from 0x0053
// R7 - low reset input resets the whole block
// R8 - external logic holds reset at least 200 us on a running device
// R9 - writing power-down bit 1 stops oscillator and PLL
// R10 - wakeup restarts oscillator, after PLL settles raises wakeup interrupt
// R11 - usb activity, dedicated wake pin or secondary wake pin leave power-down
// R12 - secondary wake pin may serve as general-purpose I/O instead
// R13 - dedicated wake pin is active low after reset unless repolarised
// R14 - 128-byte waveform descriptor store mapped at E400..E47F
// R15 - enabled secondary pin transition wakes; held asserted it blocks suspend
module fav_top
	import fav_pkg::*;
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic [31:0] hrdata,
	output logic hresp,
	input wire logic [fav_pkg::NUM_SRC-1:0] src_irq,
	input wire fav_pkg::fav_pins_t pins_in,
	input wire logic [15:0] code_addr,
	input wire logic [7:0] code_rdata_in,
	input wire logic irq_take,
	output logic [7:0] code_rdata,
	output logic group_irq,
	output logic push_pc,
	output logic redirect,
	output logic [15:0] redirect_addr,
	output logic osc_en,
	output logic pll_en,
	output logic suspended,
	output logic irq,
	output logic wu2_out,
	output logic wu2_oe
);
	import fav_pkg::*;

	fav_state_t st_ff;
	fav_state_t nxt_st;
	logic [NUM_SRC-1:0] active;
	logic [7:0] vec_byte;
	logic any_active;
	logic addr_phase;
	logic [11:0] aofs;
	logic [31:0] rd_mux;
	logic wake_lvl;
	logic wu2_lvl;
	logic wu2_edge;
	logic wu2_wake_src;
	logic wake_event;
	logic [NUM_SRC-1:0] pend_clr;

	// ****************************************
	// priority vector encoder
	// ****************************************

	// sources sit in priority order: bit 0 is priority 1, bit 13 priority 14
	assign active = st_ff.pend & st_ff.src_en;

	// scan from the weakest so the strongest pending source is written last
	always_comb begin
		vec_byte = VEC_BASE;
		any_active = 1'b0;
		for (int i = NUM_SRC - 1; i >= 0; i--) begin
			if (active[i]) begin
				vec_byte = VEC_BASE + 8'(i * 4); // R1 R2 R3
				any_active = 1'b1; // R4
			end
		end
	end

	// ****************************************
	// pin decode
	// ****************************************

	// polarity bit 0 means the dedicated pin wakes when low
	assign wake_lvl = st_ff.sync2.wake_pin ^ ~st_ff.setup[SETUP_WAKE_POL]; // R13
	assign wu2_lvl = st_ff.sync2.wu2_pin ^ ~st_ff.setup[SETUP_WU2_POL];
	assign wu2_edge = st_ff.sync2.wu2_pin ^ st_ff.wu2_prev;
	// in gpio mode the pin no longer counts as a wake source
	assign wu2_wake_src = st_ff.setup[SETUP_WU2_EN] & ~st_ff.setup[SETUP_WU2_GPIO]; // R12
	assign wake_event = st_ff.sync2.usb_activity | wake_lvl | (wu2_wake_src & wu2_edge); // R11 R15

	// ****************************************
	// bus decode and read mux
	// ****************************************

	assign addr_phase = hsel & htrans[1] & hready;
	assign aofs = st_ff.acc_addr;

	// reads are served one cycle late so a preceding write is always visible
	always_comb begin
		rd_mux = 32'h0000_0000;
		case (aofs)
			OFS_SETUP: rd_mux[4:0] = st_ff.setup;
			OFS_SRC_EN: rd_mux[NUM_SRC-1:0] = st_ff.src_en;
			OFS_SRC_PEND: rd_mux[NUM_SRC-1:0] = st_ff.pend;
			OFS_VECTOR: rd_mux[7:0] = vec_byte;
			OFS_PWR: rd_mux[PWR_DOWN_BIT] = (st_ff.pstate != PW_RUN);
			OFS_IRQ_STAT: rd_mux[1:0] = st_ff.stat;
			OFS_IRQ_EN: rd_mux[1:0] = st_ff.irq_en;
			OFS_GPIO: rd_mux[2:0] = {st_ff.sync2.wu2_pin, st_ff.gpio};
			default: begin
				if (aofs >= OFS_WAVE_BASE && aofs <= OFS_WAVE_LAST) begin
					rd_mux = st_ff.wave[aofs[6:2]]; // R14
				end
			end
		endcase
	end

	// pending bits cleared by a one written to the pending register
	assign pend_clr = (st_ff.wr_pend && aofs == OFS_SRC_PEND) ? hwdata[NUM_SRC-1:0] : '0;

	// ****************************************
	// next state
	// ****************************************
	always_comb begin
		nxt_st = st_ff;

		// two-flop synchronisers on every pin input
		nxt_st.sync1 = pins_in;
		nxt_st.sync2 = st_ff.sync1;
		nxt_st.wu2_prev = st_ff.sync2.wu2_pin;

		// address phase capture; reads stall one cycle
		nxt_st.hreadyout = 1'b1;
		nxt_st.rd_pend = 1'b0;
		nxt_st.wr_pend = 1'b0;
		if (addr_phase) begin
			nxt_st.acc_addr = {haddr[11:2], 2'b00};
			nxt_st.rd_pend = ~hwrite;
			nxt_st.wr_pend = hwrite;
			nxt_st.hreadyout = hwrite;
		end
		if (st_ff.rd_pend) begin
			nxt_st.hrdata = rd_mux;
		end

		// source capture: rising edge sets, set wins over clear
		nxt_st.src_prev = src_irq;
		nxt_st.pend = (st_ff.pend & ~pend_clr) | (src_irq & ~st_ff.src_prev);

		// register writes in the data phase
		if (st_ff.wr_pend) begin
			case (aofs)
				OFS_SETUP: nxt_st.setup = hwdata[4:0];
				OFS_SRC_EN: nxt_st.src_en = hwdata[NUM_SRC-1:0];
				OFS_IRQ_EN: nxt_st.irq_en = hwdata[1:0];
				OFS_GPIO: nxt_st.gpio = hwdata[1:0];
				default: begin
					if (aofs >= OFS_WAVE_BASE && aofs <= OFS_WAVE_LAST) begin
						nxt_st.wave[aofs[6:2]] = hwdata; // R14
					end
				end
			endcase
		end

		// status clear first, events below override it
		if (st_ff.wr_pend && aofs == OFS_IRQ_CLR) begin
			nxt_st.stat = st_ff.stat & ~hwdata[1:0];
		end

		// power sequencer
		case (st_ff.pstate)
			PW_RUN: begin
				if (st_ff.wr_pend && aofs == OFS_PWR && hwdata[PWR_DOWN_BIT]) begin
					// held secondary pin vetoes suspend; software sees it in status
					if (wu2_wake_src && wu2_lvl) begin
						nxt_st.stat[STAT_BLOCKED] = 1'b1; // R15
					end else begin
						nxt_st.pstate = PW_DOWN; // R9
						nxt_st.osc_en = 1'b0;
						nxt_st.pll_en = 1'b0;
					end
				end
			end
			PW_DOWN: begin
				if (wake_event) begin
					nxt_st.pstate = PW_LOCK; // R10
					nxt_st.osc_en = 1'b1;
					nxt_st.pll_en = 1'b1;
					nxt_st.pll_cnt = PLL_CNT_LOAD;
				end
			end
			PW_LOCK: begin
				// wakeup interrupt only after the PLL settle count runs out
				if (st_ff.pll_cnt <= 8'h01) begin
					nxt_st.pstate = PW_RUN;
					nxt_st.stat[STAT_WAKE] = 1'b1; // R10
				end else begin
					nxt_st.pll_cnt = st_ff.pll_cnt - 8'h01;
				end
			end
			default: begin
				nxt_st.pstate = PW_RUN;
			end
		endcase

		// interrupt outputs
		nxt_st.irq = |(nxt_st.stat & st_ff.irq_en);
		// registered copies so these pins come straight from a flop
		nxt_st.suspended = ~nxt_st.osc_en; // R9
		nxt_st.wu2_oe = nxt_st.gpio[GPIO_OE] & nxt_st.setup[SETUP_WU2_GPIO]; // R12
		nxt_st.group_irq = any_active;

		// program fetch: patch the vector byte when autovectoring
		if (st_ff.setup[SETUP_AV_EN] && code_addr == VEC_BYTE_LOC) begin
			nxt_st.code_rdata = vec_byte; // R5
		end else begin
			nxt_st.code_rdata = code_rdata_in;
		end

		// take sequence: push first, then redirect to the jump slot
		nxt_st.push_pc = irq_take; // R6
		nxt_st.take_stage = irq_take;
		nxt_st.redirect = st_ff.take_stage; // R6
		nxt_st.redirect_addr = JUMP_LOC;
	end

	// ****************************************
	// state register
	// ****************************************

	// constant reset values only; reset clears vectoring and wake config
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			st_ff <= '0; // R7
			st_ff.hreadyout <= 1'b1;
			st_ff.osc_en <= 1'b1;
			st_ff.pll_en <= 1'b1;
			st_ff.pstate <= PW_RUN;
			st_ff.redirect_addr <= JUMP_LOC;
		end else begin
			st_ff <= nxt_st;
		end
	end

	// ****************************************
	// outputs
	// ****************************************
	assign hreadyout = st_ff.hreadyout;
	assign hrdata = st_ff.hrdata;
	assign hresp = 1'b0;
	assign code_rdata = st_ff.code_rdata;
	assign group_irq = st_ff.group_irq;
	assign push_pc = st_ff.push_pc;
	assign redirect = st_ff.redirect;
	assign redirect_addr = st_ff.redirect_addr;
	assign osc_en = st_ff.osc_en;
	assign pll_en = st_ff.pll_en;
	assign irq = st_ff.irq;
	// gpio mode drives the shared pin from its own register
	assign wu2_out = st_ff.gpio[GPIO_OUT]; // R12
	assign wu2_oe = st_ff.wu2_oe; // R12
	assign suspended = st_ff.suspended;

endmodule

/* File: tb/fav_asserts.sv */
// port checks for the autovector and wakeup block
`timescale 1ns/1ps
module fav_checker
	import fav_pkg::*;
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic hready,
	input wire logic hreadyout,
	input wire logic hresp,
	input wire logic irq_take,
	input wire logic push_pc,
	input wire logic redirect,
	input wire logic [15:0] redirect_addr,
	input wire logic [15:0] code_addr,
	input wire logic [7:0] code_rdata_in,
	input wire logic [7:0] code_rdata,
	input wire logic osc_en,
	input wire logic pll_en,
	input wire logic suspended
);
	// ****
	// properties
	// ****
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	// take then stack push, one cycle apart
	sequence s_take;
		irq_take ##1 push_pc;
	endsequence
	property p_push; irq_take |=> push_pc; endproperty
	a_push: assert property (p_push) else $error("push missing after take");
	property p_redir; s_take |=> redirect && redirect_addr == JUMP_LOC; endproperty
	a_redir: assert property (p_redir) else $error("redirect missing or wrong");
	property p_lone; redirect |-> $past(irq_take, 2); endproperty
	a_lone: assert property (p_lone) else $error("redirect without take");
	// only the vector slot may differ from the store
	property p_code; $past(hresetn) && code_addr != VEC_BYTE_LOC |=> code_rdata == $past(code_rdata_in); endproperty
	a_code: assert property (p_code) else $error("fetch byte altered");
	property p_down; suspended == !osc_en && pll_en == osc_en; endproperty
	a_down: assert property (p_down) else $error("clock enables disagree");
	property p_rdw; hsel && htrans[1] && hready && !hwrite |=> !hreadyout ##1 hreadyout; endproperty
	a_rdw: assert property (p_rdw) else $error("read wait state wrong");
	property p_wrz; hsel && htrans[1] && hready && hwrite |=> hreadyout; endproperty
	a_wrz: assert property (p_wrz) else $error("write stalled");
	property p_okay; hresp == 1'h0; endproperty
	a_okay: assert property (p_okay) else $error("response not okay");
endmodule
bind fav_top fav_checker fav_checker_inst (.*);

/* File: tb/fav_core_model.sv */
// processor core model: takes the group request and fetches the jump slot
`timescale 1ns/1ps
module fav_core_model (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic group_irq,
	input wire logic redirect,
	input wire logic [7:0] code_rdata,
	output logic irq_take,
	output logic [15:0] code_addr,
	output logic [7:0] code_rdata_in,
	output logic [7:0] vec_seen
);
	logic grp_ff;
	logic take_ff;
	logic [2:0] cnt_ff;
	logic [15:0] addr_ff;
	logic [7:0] vec_ff;
	// store answers every fetch, byte derived from the address
	assign code_rdata_in = ~code_addr[7:0];
	assign irq_take = take_ff;
	assign code_addr = addr_ff;
	assign vec_seen = vec_ff;
	// one take per new request; after redirect walk 0053..0055, keep the 0055 byte
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			grp_ff <= 1'h0;
			take_ff <= 1'h0;
			cnt_ff <= 3'h0;
			addr_ff <= 16'h0100;
			vec_ff <= 8'h00;
		end else begin
			grp_ff <= group_irq;
			take_ff <= group_irq & ~grp_ff;
			if (redirect) begin
				cnt_ff <= 3'h4;
				addr_ff <= 16'h0053;
			end else if (cnt_ff != 3'h0) begin
				cnt_ff <= cnt_ff - 3'h1;
				if (cnt_ff > 3'h2)
					addr_ff <= addr_ff + 16'h0001;
				if (cnt_ff == 3'h1)
					vec_ff <= code_rdata;
			end
		end
	end
endmodule

/* File: tb/fav_top_tb.sv */
// bench for the autovector and wakeup block
`timescale 1ns/1ps
module fav_top_tb;
	import fav_pkg::*;
	logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, irq_take;
	logic [31:0] haddr, hwdata, hrdata;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic [NUM_SRC-1:0] src_irq;
	fav_pins_t pins_in;
	logic [15:0] code_addr, redirect_addr;
	logic [7:0] code_rdata_in, code_rdata, vec_seen;
	logic group_irq, push_pc, redirect, osc_en, pll_en, suspended, irq, wu2_out, wu2_oe;
	int n_mismatch, checks_done, i, k;
	assign hready = hreadyout;
	fav_top fav_top_inst (.*);
	fav_core_model fav_core_model_inst (.*);
	// ****
	// tasks
	// ****
	task automatic finish_test();
		if (n_mismatch == 0 && checks_done > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		checks_done++;
		if (s !== e) begin
			n_mismatch++;
			$display("ERROR %0t seen %h expected %h", $time, s, e);
		end
	endtask
	// a wait that ran out ends the run at once
	task automatic to(input logic ok);
		chk(ok, 1'h1);
		if (ok !== 1'h1)
			finish_test();
	endtask
	task automatic rdy();
		int n;
		n = 0;
		@(posedge hclk);
		while (hreadyout !== 1'h1) begin
			n++;
			to(n < 20);
			@(posedge hclk);
		end
	endtask
	// one single transfer; an idle edge follows so signals never change twice at once
	task automatic xf(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q);
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= {20'h0, a};
		rdy();
		htrans <= 2'h0;
		hwdata <= d;
		rdy();
		q = hrdata;
		@(posedge hclk);
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] q;
		xf(1'h1, a, d, q);
	endtask
	task automatic rc(input logic [11:0] a, input logic [31:0] e);
		logic [31:0] q;
		xf(1'h0, a, 32'h0, q);
		chk(q, e);
	endtask
	// ****
	// clock and sequence
	// ****
	initial begin
		hclk = 1'h0;
		forever #12.5 hclk = ~hclk;
	end
	initial begin
		{hresetn, hwrite, htrans, haddr, hwdata, src_irq} = '0;
		hsel = 1'h1;
		hsize = 3'h2;
		pins_in = 3'h3;
		n_mismatch = 0;
		checks_done = 0;
		repeat (10) @(posedge hclk);
		hresetn <= 1'h1;
		@(posedge hclk);
		rc(OFS_VECTOR, 32'h80);
		rc(12'h0FC, 32'h0);
		wr(OFS_SRC_EN, 32'h3FFF);
		// raise sources from lowest rank upward; each newcomer must win
		for (i = 13; i >= 0; i--) begin
			src_irq[i] <= 1'h1;
			repeat (2) @(posedge hclk);
			rc(OFS_VECTOR, 32'h80 + 4 * i);
		end
		chk(vec_seen, 8'hAA);
		for (i = 0; i < 14; i++) begin
			wr(OFS_SRC_PEND, 32'h1 << i);
			rc(OFS_VECTOR, i < 13 ? 32'h84 + 4 * i : 32'h80);
		end
		src_irq <= '0;
		wr(OFS_SETUP, 32'h1);
		src_irq[5] <= 1'h1;
		for (i = 0; i < 30 && vec_seen !== 8'h94; i++)
			@(posedge hclk);
		to(vec_seen === 8'h94);
		src_irq <= '0;
		wr(OFS_SRC_PEND, 32'h20);
		wr(OFS_IRQ_EN, 32'h1);
		// wake by secondary pin, dedicated pin, then usb activity
		for (k = 0; k < 3; k++) begin
			wr(OFS_SETUP, k == 0 ? 32'h2 : 32'h0);
			wr(OFS_PWR, 32'h1);
			@(posedge hclk);
			chk(suspended, 1'h1);
			chk(pll_en, 1'h0);
			pins_in <= pins_in ^ (3'h1 << k);
			for (i = 0; i < 10 && osc_en !== 1'h1; i++)
				@(posedge hclk);
			to(osc_en === 1'h1);
			chk(irq, 1'h0);
			for (i = 0; i < 60 && irq !== 1'h1; i++)
				@(posedge hclk);
			to(irq === 1'h1);
			pins_in <= pins_in ^ (3'h1 << k);
			wr(OFS_IRQ_CLR, 32'h1);
			rc(OFS_IRQ_STAT, 32'h0);
		end
		wr(OFS_SETUP, 32'h2);
		pins_in.wu2_pin <= 1'h0;
		repeat (3) @(posedge hclk);
		wr(OFS_PWR, 32'h1);
		@(posedge hclk);
		chk(osc_en, 1'h1);
		rc(OFS_IRQ_STAT, 32'h2);
		pins_in.wu2_pin <= 1'h1;
		wr(OFS_IRQ_CLR, 32'h2);
		wr(OFS_SETUP, 32'h10);
		wr(OFS_GPIO, 32'h3);
		@(posedge hclk);
		chk({wu2_oe, wu2_out}, 2'h3);
		rc(OFS_GPIO, 32'h7);
		wr(OFS_WAVE_LAST, 32'hC3A55A3C);
		rc(OFS_WAVE_LAST, 32'hC3A55A3C);
		// powered reset held for the full minimum time
		hresetn <= 1'h0;
		repeat (RESET_HOLD_US * 1000 / CLK_PERIOD_NS) @(posedge hclk);
		hresetn <= 1'h1;
		@(posedge hclk);
		rc(OFS_SETUP, 32'h0);
		chk(wu2_oe, 1'h0);
		finish_test();
	end
endmodule
